// File: rtl/smc_slave.sv
`timescale 1ns/1ns
`include "smc_defs.svh"

// Operation
// RULE_01: Acts only as bus slave; receives and returns bytes on clock and data lines.
// RULE_02: Master reads and writes every read/write configuration register.
// RULE_03: Read-only and preloaded registers are also readable and writable.
// RULE_04: Address bits 2:0 follow the three strap pins, lowest pin to bit 0.
// RULE_05: Address bits 6:3 fixed at one, zero, one, one; the code fixes them at one, one, zero, one (4'hD).
// RULE_06: Software may replace the whole 7-bit slave address.
// RULE_07: Only block write, block read and the process call are supported.
// RULE_08: Packet error code is checked on receive and generated on returned data.
// RULE_09: Block write with code BEh writes a configuration register.
// RULE_10: Block write BAh then block read BDh returns register contents.
// RULE_11: Process call with BAh then CDh returns register data in read phase.
// RULE_12: Register write byte count is eight; error code byte not counted.
// RULE_13: Wrong code or count is refused from that byte through packet end.
// RULE_14: Failing error code drops the write and refuses that byte unless disabled.
// RULE_15: First command byte bits 2:0: 011b write, 100b read.
// RULE_16: Only a matching 7-bit address is acknowledged.
module smc_slave (
   // Clock and reset
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_rst,
   // Bus pins
   input  wire logic                  i_scl,
   input  wire logic                  i_sda,
   output smc_pkg::smc_od_t           o_scl,
   output smc_pkg::smc_od_t           o_sda,
   // Address straps and control
   input  wire logic [2:0]            i_addr_strap,
   input  wire logic                  i_addr_we,
   input  wire logic [6:0]            i_addr_new,
   input  wire logic                  i_pec_chk_dis,
   output logic      [6:0]            o_addr,
   // Configuration space port
   output logic                       o_cfg_req,
   output smc_pkg::smc_cfg_req_t      o_cfg,
   input  wire logic                  i_cfg_ack,
   input  wire logic [31:0]           i_cfg_rdata
);
   import smc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic [4:0]   pins;
   logic         scl_f;
   logic         sda_f;
   logic [2:0]   strap_f;
   logic         scl_q;
   logic         sda_q;
   logic         scl_rise;
   logic         scl_fall;
   logic         start;
   logic         stop;
   logic [7:0]   crc;
   logic         pec_en;
   logic         sw_set;
   logic         next_sw_set;
   logic [6:0]   next_addr;

   smc_sync #(
      .W    (5),
      .INIT (5'h1F)
   ) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_async   ({i_scl, i_sda, i_addr_strap}),
      .o_level   (pins)
   );

   assign scl_f    = pins[4];
   assign sda_f    = pins[3];
   assign strap_f  = pins[2:0];
   assign scl_rise = scl_f & ~scl_q;
   assign scl_fall = ~scl_f & scl_q;
   assign start    = scl_f & scl_q & sda_q & ~sda_f;
   assign stop     = scl_f & scl_q & ~sda_q & sda_f;

   // Slave only: the clock line is never driven
   assign o_scl = '{o: 1'b0, oe: 1'b0}; // [RULE_01]

   ////////////////////////////////////////////////////////////////////////////
   // Slave address
   always_comb
   begin
      next_sw_set = sw_set | i_addr_we;
      if (i_addr_we)
         next_addr = i_addr_new; // [RULE_06]
      else if (!sw_set)
         next_addr = {`SMC_ADDR_HI, strap_f}; // [RULE_04] [RULE_05]
      else
         next_addr = o_addr;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         sw_set <= 1'b0;
         o_addr <= {`SMC_ADDR_HI, 3'h7};
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
      end
      else
      begin
         sw_set <= next_sw_set;
         o_addr <= next_addr;
         scl_q  <= scl_f;
         sda_q  <= sda_f;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Protocol engine
   smc_state_t   st, next_st;
   logic [3:0]   bit_cnt, next_bit_cnt;
   logic [7:0]   sh, next_sh;
   logic [3:0]   pos, next_pos;
   logic [7:0]   cmd, next_cmd;
   logic         err, next_err;
   logic [31:0]  cb, next_cb;
   logic [31:0]  db, next_db;
   logic         wr_ok, next_wr_ok;
   logic         rd_arm, next_rd_arm;
   logic         rd_pend, next_rd_pend;
   logic         rd_valid, next_rd_valid;
   logic [31:0]  rd_data, next_rd_data;
   logic         txn, next_txn;
   logic         rd_phase, next_rd_phase;
   logic [2:0]   tx_idx, next_tx_idx;
   logic         mack, next_mack;
   logic         sda_oe, next_sda_oe;
   logic         next_cfg_req;
   smc_cfg_req_t next_cfg;
   logic         is_wr;
   logic         is_rd;
   logic         cmd_ok;
   logic         pec_ok;
   logic         byte_ok;

   function automatic logic [7:0] tx_byte(input logic [2:0] idx, input logic [31:0] d,
                                          input logic [7:0] c);
      case (idx)
         3'h0:    tx_byte = `SMC_RD_COUNT;
         3'h1:    tx_byte = d[31:24];
         3'h2:    tx_byte = d[23:16];
         3'h3:    tx_byte = d[15:8];
         3'h4:    tx_byte = d[7:0];
         default: tx_byte = c; // [RULE_08]
      endcase
   endfunction : tx_byte

   assign is_wr  = (cmd == `SMC_CMD_WRITE);
   assign is_rd  = (cmd == `SMC_CMD_RDREQ) | (cmd == `SMC_CMD_PCALL);
   assign cmd_ok = (sh == `SMC_CMD_WRITE) | (sh == `SMC_CMD_RDREQ) |
                   (sh == `SMC_CMD_RDBLK) | (sh == `SMC_CMD_PCALL); // [RULE_07]
   // Code includes the received error byte, so a good packet leaves zero
   assign pec_ok = (crc == 8'h00) | i_pec_chk_dis; // [RULE_08] [RULE_14]
   // Received bits enter at their fall so a repeated start's clock rise adds none; bit eight enters at its rise
   assign pec_en = (scl_rise & (st == smc_tx)) |
                   ((st == smc_rx) & ((scl_fall & (bit_cnt != 4'h0) & (bit_cnt != `SMC_BIT_FULL)) |
                                      (scl_rise & (bit_cnt == `SMC_BIT_LAST))));

   smc_pec u_pec (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_clr     (start & ~txn),
      .i_en      (pec_en),
      .i_bit     (sda_f),
      .o_crc     (crc)
   );

   // Acceptance of a data-phase byte
   always_comb
   begin
      byte_ok = 1'b0;
      if (pos == `SMC_POS_CNT)
         byte_ok = is_wr ? (sh == `SMC_WR_COUNT) : (is_rd & (sh == `SMC_RD_COUNT)); // [RULE_12]
      else if (pos == `SMC_POS_CB1)
         byte_ok = (is_wr | is_rd) & (sh[2:0] == (is_wr ? `SMC_OP_WR : `SMC_OP_RD)); // [RULE_15]
      else if (pos > `SMC_POS_CB1 && pos <= `SMC_POS_CB4)
         byte_ok = 1'b1;
      else if (pos == `SMC_POS_RPEC)
         byte_ok = is_wr | (is_rd & pec_ok);
      else if (pos > `SMC_POS_RPEC && pos <= `SMC_POS_D4)
         byte_ok = is_wr;
      else if (pos == `SMC_POS_WPEC)
         byte_ok = is_wr & pec_ok; // [RULE_14]
      byte_ok = byte_ok & ~err; // [RULE_13]
   end

   always_comb
   begin
      next_st       = st;
      next_bit_cnt  = bit_cnt;
      next_sh       = sh;
      next_pos      = pos;
      next_cmd      = cmd;
      next_err      = err;
      next_cb       = cb;
      next_db       = db;
      next_wr_ok    = wr_ok;
      next_rd_arm   = rd_arm;
      next_rd_pend  = rd_pend;
      next_rd_valid = rd_valid;
      next_rd_data  = rd_data;
      next_txn      = txn;
      next_rd_phase = rd_phase;
      next_tx_idx   = tx_idx;
      next_mack     = mack;
      next_sda_oe   = sda_oe;
      next_cfg_req  = 1'b0;
      next_cfg      = o_cfg;
      if (rd_pend && i_cfg_ack)
      begin
         next_rd_pend  = 1'b0;
         next_rd_valid = 1'b1;
         next_rd_data  = i_cfg_rdata;
      end
      if (start || stop)
      begin
         // Accepted packet is executed at its stop or repeated start
         if (wr_ok || rd_arm)
         begin
            next_cfg_req = 1'b1; // [RULE_02] [RULE_03]
            next_cfg     = '{wr: wr_ok, port: {cb[19:16], cb[15]}, addr: cb[9:0],
                             be: cb[13:10], wdata: db}; // [RULE_09]
            next_rd_pend = rd_arm; // [RULE_10] [RULE_11]
            if (rd_arm)
               next_rd_valid = 1'b0;
         end
         next_wr_ok    = 1'b0;
         next_rd_arm   = 1'b0;
         next_sda_oe   = 1'b0;
         next_bit_cnt  = 4'h0;
         next_pos      = `SMC_POS_ADR;
         next_err      = 1'b0;
         next_rd_phase = 1'b0;
         next_txn      = start;
         next_st       = start ? smc_rx : smc_idle;
      end
      else
      begin
         case (st)
            smc_rx:
            begin
               if (scl_rise && bit_cnt != `SMC_BIT_FULL)
               begin
                  next_sh      = {sh[6:0], sda_f};
                  next_bit_cnt = bit_cnt + 4'h1;
               end
               else if (scl_fall && bit_cnt == `SMC_BIT_FULL)
               begin
                  next_bit_cnt = 4'h0;
                  next_st      = smc_ack;
                  if (pos != `SMC_POS_MAX)
                     next_pos = pos + 4'h1;
                  if (pos == `SMC_POS_ADR)
                  begin
                     if (sh[7:1] != o_addr)
                        next_st = smc_idle; // [RULE_16]
                     else
                     begin
                        next_rd_phase = sh[0];
                        next_tx_idx   = 3'h0;
                        next_sda_oe   = ~sh[0] | (rd_valid & ((cmd == `SMC_CMD_RDBLK) |
                                        (cmd == `SMC_CMD_PCALL))); // [RULE_10] [RULE_11]
                     end
                  end
                  else if (pos == `SMC_POS_CMD)
                  begin
                     next_cmd    = sh;
                     next_err    = ~cmd_ok; // [RULE_13]
                     next_sda_oe = cmd_ok; // [RULE_07]
                     if (sh != `SMC_CMD_RDBLK)
                        next_rd_valid = 1'b0;
                  end
                  else
                  begin
                     next_err    = ~byte_ok; // [RULE_13]
                     next_sda_oe = byte_ok;
                     if (pos <= `SMC_POS_CB4)
                        next_cb = {cb[23:0], sh};
                     else if (pos <= `SMC_POS_D4)
                        next_db = {db[23:0], sh};
                     if (pos == `SMC_POS_CB4)
                        next_rd_arm = byte_ok & is_rd;
                     if (pos == `SMC_POS_RPEC && is_rd)
                        next_rd_arm = byte_ok;
                     if (pos == `SMC_POS_D4)
                        next_wr_ok = byte_ok;
                     if (pos == `SMC_POS_WPEC)
                        next_wr_ok = byte_ok; // [RULE_14]
                  end
               end
            end
            smc_ack:
            begin
               if (scl_fall)
               begin
                  next_sda_oe = 1'b0;
                  if (rd_phase)
                  begin
                     if (sda_oe)
                     begin
                        next_st     = smc_tx;
                        next_sh     = tx_byte(tx_idx, rd_data, crc);
                        next_sda_oe = ~next_sh[7];
                     end
                     else
                        next_st = smc_idle;
                  end
                  else
                     next_st = smc_rx;
               end
            end
            smc_tx:
            begin
               if (scl_fall)
               begin
                  if (bit_cnt == `SMC_BIT_LAST)
                  begin
                     next_sda_oe  = 1'b0;
                     next_bit_cnt = 4'h0;
                     next_st      = smc_txack;
                  end
                  else
                  begin
                     next_bit_cnt = bit_cnt + 4'h1;
                     next_sh      = {sh[6:0], 1'b0};
                     next_sda_oe  = ~sh[6];
                  end
               end
            end
            smc_txack:
            begin
               if (scl_rise)
                  next_mack = sda_f;
               else if (scl_fall)
               begin
                  if (!mack && tx_idx != `SMC_TX_LAST)
                  begin
                     next_tx_idx = tx_idx + 3'h1;
                     next_sh     = tx_byte(next_tx_idx, rd_data, crc); // [RULE_08]
                     next_sda_oe = ~next_sh[7];
                     next_st     = smc_tx;
                  end
                  else
                     next_st = smc_idle;
               end
            end
            default:
               next_st = smc_idle;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         st        <= smc_idle;
         bit_cnt   <= 4'h0;
         sh        <= 8'h00;
         pos       <= `SMC_POS_ADR;
         cmd       <= 8'h00;
         err       <= 1'b0;
         cb        <= 32'h0000_0000;
         db        <= 32'h0000_0000;
         wr_ok     <= 1'b0;
         rd_arm    <= 1'b0;
         rd_pend   <= 1'b0;
         rd_valid  <= 1'b0;
         rd_data   <= 32'h0000_0000;
         txn       <= 1'b0;
         rd_phase  <= 1'b0;
         tx_idx    <= 3'h0;
         mack      <= 1'b1;
         sda_oe    <= 1'b0;
         o_cfg_req <= 1'b0;
         o_cfg     <= '0;
      end
      else
      begin
         st        <= next_st;
         bit_cnt   <= next_bit_cnt;
         sh        <= next_sh;
         pos       <= next_pos;
         cmd       <= next_cmd;
         err       <= next_err;
         cb        <= next_cb;
         db        <= next_db;
         wr_ok     <= next_wr_ok;
         rd_arm    <= next_rd_arm;
         rd_pend   <= next_rd_pend;
         rd_valid  <= next_rd_valid;
         rd_data   <= next_rd_data;
         txn       <= next_txn;
         rd_phase  <= next_rd_phase;
         tx_idx    <= next_tx_idx;
         mack      <= next_mack;
         sda_oe    <= next_sda_oe;
         o_cfg_req <= next_cfg_req;
         o_cfg     <= next_cfg;
      end
   end

   assign o_sda = '{o: 1'b0, oe: sda_oe};

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb_chk @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   property p_scl_free;
      o_scl.oe == 1'b0;
   endproperty
   a_scl_free: assert property (p_scl_free) // [RULE_01]
      else $error("clock line driven");

   property p_strap;
      (!sw_set && !i_addr_we) |=> o_addr[2:0] == $past(strap_f);
   endproperty
   a_strap: assert property (p_strap) // [RULE_04]
      else $error("address low bits do not follow straps");

   property p_addr_hi;
      !sw_set |-> o_addr[6:3] == `SMC_ADDR_HI;
   endproperty
   a_addr_hi: assert property (p_addr_hi) // [RULE_05]
      else $error("fixed address bits wrong");

   property p_sw_addr;
      i_addr_we |=> (o_addr == $past(i_addr_new)) && sw_set;
   endproperty
   a_sw_addr: assert property (p_sw_addr) // [RULE_06]
      else $error("software address not taken");

   property p_mismatch;
      (st == smc_rx && scl_fall && bit_cnt == `SMC_BIT_FULL && pos == `SMC_POS_ADR &&
       sh[7:1] != o_addr && !start && !stop) |=> !o_sda.oe && st == smc_idle;
   endproperty
   a_mismatch: assert property (p_mismatch) // [RULE_16]
      else $error("foreign address acknowledged");

   property p_err_nack;
      (st == smc_ack && err && !rd_phase) |-> !o_sda.oe;
   endproperty
   a_err_nack: assert property (p_err_nack) // [RULE_13]
      else $error("faulty byte acknowledged");

   property p_bad_cmd;
      (st == smc_rx && scl_fall && bit_cnt == `SMC_BIT_FULL && pos == `SMC_POS_CMD &&
       !cmd_ok && !start && !stop) |=> err ##1 !o_sda.oe;
   endproperty
   a_bad_cmd: assert property (p_bad_cmd) // [RULE_07]
      else $error("unsupported command accepted");

   property p_pec_fail;
      (st == smc_rx && scl_fall && bit_cnt == `SMC_BIT_FULL && pos == `SMC_POS_WPEC &&
       is_wr && crc != 8'h00 && !i_pec_chk_dis && !start && !stop) |=> !wr_ok && !sda_oe;
   endproperty
   a_pec_fail: assert property (p_pec_fail) // [RULE_14]
      else $error("bad error code accepted");

   property p_wr_issue;
      (o_cfg_req && o_cfg.wr) |-> $past(cmd) == `SMC_CMD_WRITE && $past(pos) >= `SMC_POS_D4;
   endproperty
   a_wr_issue: assert property (p_wr_issue) // [RULE_09]
      else $error("write issued without full packet");

   property p_rd_issue;
      (o_cfg_req && !o_cfg.wr) |-> $past(is_rd) && rd_pend && !rd_valid;
   endproperty
   a_rd_issue: assert property (p_rd_issue) // [RULE_10]
      else $error("read issued without read request");

   property p_count;
      (st == smc_rx && scl_fall && bit_cnt == `SMC_BIT_FULL && pos == `SMC_POS_CNT && is_wr &&
       sh != `SMC_WR_COUNT && !start && !stop) |=> err;
   endproperty
   a_count: assert property (p_count) // [RULE_12]
      else $error("wrong byte count accepted");

endmodule : smc_slave

// File: rtl/smc_defs.svh
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// Fixed upper slave address bits 6:3
`define SMC_ADDR_HI    4'hD
// Command codes
`define SMC_CMD_WRITE  8'hBE
`define SMC_CMD_RDREQ  8'hBA
`define SMC_CMD_RDBLK  8'hBD
`define SMC_CMD_PCALL  8'hCD
// Byte counts
`define SMC_WR_COUNT   8'h08
`define SMC_RD_COUNT   8'h04
// Operation field of the first command byte
`define SMC_OP_WR      3'h3
`define SMC_OP_RD      3'h4
// Packet error code polynomial x^8+x^2+x+1
`define SMC_PEC_POLY   8'h07
// Byte positions within a write phase
`define SMC_POS_ADR    4'h0
`define SMC_POS_CMD    4'h1
`define SMC_POS_CNT    4'h2
`define SMC_POS_CB1    4'h3
`define SMC_POS_CB4    4'h6
`define SMC_POS_RPEC   4'h7
`define SMC_POS_D4     4'hA
`define SMC_POS_WPEC   4'hB
`define SMC_POS_MAX    4'hF
// Read phase: count, four data bytes, error code
`define SMC_TX_LAST    3'h5
`define SMC_BIT_LAST   4'h7
`define SMC_BIT_FULL   4'h8

`endif

// File: rtl/smc_pkg.sv
package smc_pkg;

   typedef enum logic [2:0] {
      smc_idle,
      smc_rx,
      smc_ack,
      smc_tx,
      smc_txack
   } smc_state_t;

   // Open-drain pin drive
   typedef struct packed {
      logic o;
      logic oe;
   } smc_od_t;

   // Configuration space access
   typedef struct packed {
      logic        wr;
      logic [4:0]  port;
      logic [9:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } smc_cfg_req_t;

endpackage : smc_pkg

// File: rtl/smc_sync.sv
`timescale 1ns/1ns

module smc_sync #(
   parameter int          W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst,
   // Pins and filtered levels
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_level
);

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] next_level;

   // A change counts once stages two and three agree
   always_comb
   begin
      next_level = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & o_level);
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         s1      <= INIT;
         s2      <= INIT;
         s3      <= INIT;
         o_level <= INIT;
      end
      else
      begin
         s1      <= i_async;
         s2      <= s1;
         s3      <= s2;
         o_level <= next_level;
      end
   end

endmodule : smc_sync

// File: rtl/smc_pec.sv
`timescale 1ns/1ns
`include "smc_defs.svh"

module smc_pec (
   // Clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst,
   // Bit stream
   input  wire logic       i_clr,
   input  wire logic       i_en,
   input  wire logic       i_bit,
   // Running code
   output logic      [7:0] o_crc
);

   logic [7:0] next_crc;

   // Bit-serial CRC-8, MSB first
   always_comb
   begin
      next_crc = o_crc;
      if (i_clr)
         next_crc = 8'h00;
      else if (i_en)
         next_crc = {o_crc[6:0], 1'b0} ^ ((o_crc[7] ^ i_bit) ? `SMC_PEC_POLY : 8'h00);
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         o_crc <= 8'h00;
      else
         o_crc <= next_crc;
   end

endmodule : smc_pec

// File: verif/smc_master_model.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////
// Bus master on the open-drain lines, one bit every 16 reference cycles
module smc_master_model (
   // Clock and line level
   input  wire logic i_ref_clk,
   input  wire logic i_sda,
   // Line drive, high means released
   output logic      o_scl,
   output logic      o_sda
);
   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end

   task automatic w(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask : w

   // Start when v is high, stop when low
   task automatic cond(input logic v);
      w(4);
      o_sda = v;
      w(4);
      o_scl = 1'b1;
      w(8);
      o_sda = ~v;
      w(8);
      if (v)
         o_scl = 1'b0;
   endtask : cond

   // Eight bits first then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic ack);
      logic [8:0] s;
      s = {d, mack};
      for (int i = 8; i >= 0; i--)
      begin
         w(4);
         o_sda = s[i];
         w(4);
         o_scl = 1'b1;
         w(4);
         s[i] = i_sda;
         w(4);
         o_scl = 1'b0;
      end
      r   = s[8:1];
      ack = ~s[0];
   endtask : xfer
endmodule : smc_master_model

// File: verif/smbus_config_slave_bench.sv
`timescale 1ns/1ns

module smbus_config_slave_bench;
   import smc_pkg::*;
   logic         i_ref_clk, i_rst, scl_m, sda_m, i_addr_we, i_pec_chk_dis, i_cfg_ack, o_cfg_req, a;
   logic [2:0]   i_addr_strap;
   logic [6:0]   i_addr_new, o_addr, dev;
   logic [31:0]  i_cfg_rdata, mem;
   logic [7:0]   crc, r;
   logic [15:0]  acks;
   smc_od_t      o_scl, o_sda;
   smc_cfg_req_t o_cfg, seen;
   int           fails, checks, nreq, pend, lat;
   wire          scl_w = scl_m & ~o_scl.oe;
   wire          sda_w = sda_m & ~o_sda.oe;

   smc_slave u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_scl(scl_w), .i_sda(sda_w), .o_scl(o_scl),
      .o_sda(o_sda), .i_addr_strap(i_addr_strap), .i_addr_we(i_addr_we), .i_addr_new(i_addr_new),
      .i_pec_chk_dis(i_pec_chk_dis), .o_addr(o_addr), .o_cfg_req(o_cfg_req), .o_cfg(o_cfg),
      .i_cfg_ack(i_cfg_ack), .i_cfg_rdata(i_cfg_rdata));
   smc_master_model u_mst (.i_ref_clk(i_ref_clk), .i_sda(sda_w), .o_scl(scl_m), .o_sda(sda_m));

   initial
   begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end

   // Configuration space: one word, reads answered after lat cycles
   always @(negedge i_ref_clk)
   begin
      i_cfg_ack = 1'b0;
      if (pend == 1)
      begin
         i_cfg_ack   = 1'b1;
         i_cfg_rdata = mem;
      end
      if (pend > 0)
         pend--;
      if (o_cfg_req === 1'b1)
      begin
         nreq++;
         seen = o_cfg;
         if (o_cfg.wr)
            mem = o_cfg.wdata;
         else
            pend = lat;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   function automatic logic [7:0] f_crc(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] x;
      x = c ^ b;
      for (int i = 0; i < 8; i++)
         x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
      return x;
   endfunction : f_crc

   task automatic wb(input logic [7:0] b);
      u_mst.xfer(b, 1'b1, r, a);
      acks = {acks[14:0], a};
      crc  = f_crc(crc, b);
   endtask : wb

   task automatic rb(input logic last, output logic [7:0] b);
      u_mst.xfer(8'hFF, last, b, a);
      crc = f_crc(crc, b);
   endtask : rb

   // Error code mode pm: 0 none, 1 good, 2 corrupted
   task automatic pkt(input logic [6:0] ad, input logic [7:0] cc, cnt, input logic [31:0] cb, dw,
                      input logic dat, input int pm);
      acks = 16'h0000;
      crc  = 8'h00;
      u_mst.cond(1'b1);
      wb({ad, 1'b0});
      wb(cc);
      wb(cnt);
      for (int i = 3; i >= 0; i--) wb(cb[8*i +: 8]);
      if (dat)
         for (int i = 3; i >= 0; i--) wb(dw[8*i +: 8]);
      if (pm != 0)
         wb(crc ^ ((pm == 2) ? 8'h01 : 8'h00));
   endtask : pkt

   task automatic rdphase(input logic [31:0] exp);
      logic [7:0]  b;
      logic [7:0]  c;
      logic [31:0] d;
      u_mst.cond(1'b1);
      wb({dev, 1'b1});
      check("read address ack", acks[0], 1);
      rb(1'b0, b);
      check("read count", b, 8'h04);
      for (int i = 0; i < 4; i++)
      begin
         rb(1'b0, b);
         d = {d[23:0], b};
      end
      c = crc;
      rb(1'b1, b);
      check("read data", d, exp);
      check("read error code", b, c);
      u_mst.cond(1'b0);
   endtask : rdphase

   ////////////////////////////////////////////////////////////////////////
   task automatic t_write(input logic [31:0] dw);
      int n;
      n = nreq;
      pkt(dev, 8'hBE, 8'h08, 32'h0300BE45, dw, 1'b1, 1);
      u_mst.cond(1'b0);
      check("write acks", acks[11:0], 12'hFFF);
      check("write requests", nreq - n, 1);
      check("write fields", seen, {1'b1, 5'h01, 10'h245, 4'hF, dw});
      $display("write test done");
   endtask : t_write

   task automatic rf(input logic [7:0] cc, cnt, cb1, input int pm, input logic [11:0] ex, input int nr);
      int n;
      n = nreq;
      pkt(dev, cc, cnt, {cb1, 24'h00BE45}, 32'hCAFE0001, 1'b1, pm);
      u_mst.cond(1'b0);
      check("refusal acks", acks[11:0], ex);
      check("refusal requests", nreq - n, nr);
   endtask : rf

   task automatic t_refuse;
      rf(8'hAA, 8'h08, 8'h03, 1, 12'h800, 0);
      rf(8'hBE, 8'h07, 8'h03, 1, 12'hC00, 0);
      rf(8'hBE, 8'h08, 8'h04, 1, 12'hE00, 0);
      rf(8'hBE, 8'h08, 8'h03, 2, 12'hFFE, 0);
      i_pec_chk_dis = 1'b1;
      rf(8'hBE, 8'h08, 8'h03, 2, 12'hFFF, 1);
      i_pec_chk_dis = 1'b0;
      $display("refusal test done");
   endtask : t_refuse

   task automatic t_read(input logic [31:0] dw);
      lat = 40;
      pkt(dev, 8'hBA, 8'h04, 32'h0400BE45, 32'h0, 1'b0, 1);
      u_mst.cond(1'b0);
      check("read request acks", acks[7:0], 8'hFF);
      check("read request", {seen.wr, seen.addr}, {1'b0, 10'h245});
      acks = 16'h0000;
      crc  = 8'h00;
      u_mst.cond(1'b1);
      wb({dev, 1'b0});
      wb(8'hBD);
      rdphase(dw);
      pkt(dev, 8'hCD, 8'h04, 32'h0400BE45, 32'h0, 1'b0, 1);
      check("call acks", acks[7:0], 8'hFF);
      rdphase(dw);
      $display("read test done");
   endtask : t_read

   task automatic t_addr;
      int n;
      n = nreq;
      check("strap address", o_addr, 7'h6D);
      pkt(7'h6C, 8'hBE, 8'h08, 32'h0300BE45, 32'h1, 1'b1, 1);
      u_mst.cond(1'b0);
      check("foreign acks", {acks[11:0], nreq - n}, 0);
      i_addr_new = dev ^ 7'h4F;
      i_addr_we  = 1'b1;
      @(negedge i_ref_clk);
      i_addr_we = 1'b0;
      @(negedge i_ref_clk);
      check("new address", o_addr, 7'h22);
      pkt(7'h6D, 8'hBE, 8'h08, 32'h0300BE45, 32'h1, 1'b1, 1);
      u_mst.cond(1'b0);
      check("old address acks", acks[11:0], 0);
      $display("address test done");
   endtask : t_addr

   task automatic t_reset;
      i_addr_strap = 3'h2;
      i_rst        = 1'b1;
      repeat (2) @(negedge i_ref_clk);
      i_rst = 1'b0;
      repeat (10) @(negedge i_ref_clk);
      check("reset address", o_addr, 7'h6A);
      dev = 7'h6A;
      t_write(32'h0F1E2D3C);
      $display("reset test done");
   endtask : t_reset

   task automatic tally_and_finish;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      repeat (100000) @(posedge i_ref_clk);
      fails++;
      tally_and_finish();
   end

   initial
   begin
      {i_rst, i_addr_we, i_pec_chk_dis} = 3'h4;
      i_addr_new   = 7'h00;
      i_addr_strap = 3'h5;
      lat          = 2;
      dev = 7'h6D;
      repeat (2) @(negedge i_ref_clk);
      i_rst = 1'b0;
      repeat (10) @(negedge i_ref_clk);
      t_write(32'h12345678);
      t_refuse();
      t_read(32'hCAFE0001);
      t_addr();
      dev = 7'h22;
      t_write(32'h9ABCDEF0);
      t_reset();
      tally_and_finish();
   end
endmodule : smbus_config_slave_bench
